// >>> verilog/csc_pkg.sv
// Package: register map, field positions and fixed bit patterns of the
// clock synthesizer configuration bank.
// Assumes an 8-bit register address and 8-bit data from the serial engine.
package csc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_OUTPUT_ENABLE_MASK   = 8'h09;
	localparam logic [7:0] ADDR_BANK1_SOURCE_DIVIDE  = 8'h0C;
	localparam logic [7:0] ADDR_OSC_DRIVE_CONTROL    = 8'h12;
	localparam logic [7:0] ADDR_LOAD_CAP_CODE        = 8'h13;
	localparam logic [7:0] ADDR_PUMP_PRODUCT_HIGH    = 8'h40;
	localparam logic [7:0] ADDR_PRODUCT_COUNT_LOW    = 8'h41;
	localparam logic [7:0] ADDR_ODD_BIT_REF_DIVIDER  = 8'h42;
	localparam logic [7:0] ADDR_CROSSPOINT_SELECT_0  = 8'h44;
	localparam logic [7:0] ADDR_CROSSPOINT_SELECT_1  = 8'h45;
	localparam logic [7:0] ADDR_CROSSPOINT_SELECT_2  = 8'h46;
	localparam logic [7:0] ADDR_BANK2_SOURCE_DIVIDE  = 8'h47;

	// ==========================================================
	// Field positions
	localparam int OE_C_BIT      = 5;
	localparam int OE_A_BIT      = 4;
	localparam int OE_B_BIT      = 2;
	localparam int SRC_SEL_BIT   = 7;
	localparam int TUNE_HI_BIT   = 7;
	localparam int TUNE_LO_BIT   = 6;
	localparam int CAP_SRC_BIT   = 5;
	localparam int DRIVE_HI_BIT  = 4;
	localparam int DRIVE_LO_BIT  = 3;
	localparam int PUMP_HI_BIT   = 4;
	localparam int PUMP_LO_BIT   = 2;
	localparam int ODD_BIT       = 7;

	// ==========================================================
	// Fixed patterns and reset values
	localparam logic [7:0] OE_WRITE_MASK    = 8'h34;
	localparam logic [7:0] OSC_WRITE_MASK   = 8'hF8;
	localparam logic [7:0] PUMP_WRITE_MASK  = 8'h1F;
	localparam logic [7:0] PUMP_FIXED_BITS  = 8'hC0;
	localparam logic [7:0] XP0_WRITE_MASK   = 8'h03;
	localparam logic [7:0] XP1_WRITE_MASK   = 8'h8F;
	localparam logic [7:0] XP2_WRITE_MASK   = 8'hC0;
	localparam logic [7:0] REG_RESET        = 8'h00;
	localparam logic [7:0] REF_DIV_OFFSET   = 8'h02;
endpackage

// >>> verilog/csc_config_regs.sv
// Configuration register bank of the clock synthesizer.
// Assumes the serial engine on the link clock presents a one-cycle
// write strobe with address and data when a register write completes,
// and reads back the selected data registered one link clock after the address.
`timescale 1ns/1ps

module csc_config_regs
	import csc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       link_clk,
	input  wire logic       link_wr_stb,
	input  wire logic [7:0] link_addr,
	input  wire logic [7:0] link_wdata,
	output logic      [7:0] link_rdata,
	output logic            output_a_enable,
	output logic            output_b_enable,
	output logic            output_c_enable,
	output logic            bank1_source_select,
	output logic      [6:0] bank1_divide_value,
	output logic            bank2_source_select,
	output logic      [6:0] bank2_divide_value,
	output logic      [1:0] tuning_array_addr_source,
	output logic            load_cap_source,
	output logic      [1:0] osc_drive_level,
	output logic      [7:0] load_cap_code,
	output logic      [2:0] charge_pump_setting,
	output logic      [9:0] product_base_count,
	output logic            product_odd_bit,
	output logic      [6:0] ref_divide_field,
	output logic      [7:0] ref_divide_total,
	output logic      [2:0] output_a_source_select,
	output logic      [2:0] output_b_source_select,
	output logic      [2:0] output_c_source_select
);

	// ==========================================================
	// Register storage on the link clock
	logic [7:0] output_enable_mask;
	logic [7:0] bank1_source_and_divide;
	logic [7:0] oscillator_drive_control;
	logic [7:0] load_capacitor_code;
	logic [7:0] pump_and_product_high;
	logic [7:0] product_count_low;
	logic [7:0] odd_bit_and_ref_divider;
	logic [7:0] crosspoint_select_0;
	logic [7:0] crosspoint_select_1;
	logic [7:0] crosspoint_select_2;
	logic [7:0] bank2_source_and_divide;
	logic       upd_toggle;
	logic [7:0] next_rdata;

	// Reserved bits are forced by write masks so storage matches readback
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			output_enable_mask       <= REG_RESET;
			bank1_source_and_divide  <= REG_RESET;
			oscillator_drive_control <= REG_RESET;
			load_capacitor_code      <= REG_RESET;
			pump_and_product_high    <= PUMP_FIXED_BITS;
			product_count_low        <= REG_RESET;
			odd_bit_and_ref_divider  <= REG_RESET;
			crosspoint_select_0      <= ~XP0_WRITE_MASK;
			crosspoint_select_1      <= ~XP1_WRITE_MASK;
			crosspoint_select_2      <= ~XP2_WRITE_MASK;
			bank2_source_and_divide  <= REG_RESET;
		end else if (link_wr_stb) begin
			case (link_addr)
				ADDR_OUTPUT_ENABLE_MASK: begin
					output_enable_mask <= link_wdata & OE_WRITE_MASK;
				end
				ADDR_BANK1_SOURCE_DIVIDE: begin
					bank1_source_and_divide <= link_wdata;
				end
				ADDR_OSC_DRIVE_CONTROL: begin
					oscillator_drive_control <= link_wdata & OSC_WRITE_MASK;
				end
				ADDR_LOAD_CAP_CODE: begin
					load_capacitor_code <= link_wdata;
				end
				ADDR_PUMP_PRODUCT_HIGH: begin
					pump_and_product_high <= (link_wdata & PUMP_WRITE_MASK)
						| PUMP_FIXED_BITS;
				end
				ADDR_PRODUCT_COUNT_LOW: begin
					product_count_low <= link_wdata;
				end
				ADDR_ODD_BIT_REF_DIVIDER: begin
					odd_bit_and_ref_divider <= link_wdata;
				end
				ADDR_CROSSPOINT_SELECT_0: begin
					crosspoint_select_0 <= link_wdata | ~XP0_WRITE_MASK;
				end
				ADDR_CROSSPOINT_SELECT_1: begin
					crosspoint_select_1 <= link_wdata | ~XP1_WRITE_MASK;
				end
				ADDR_CROSSPOINT_SELECT_2: begin
					crosspoint_select_2 <= link_wdata | ~XP2_WRITE_MASK;
				end
				ADDR_BANK2_SOURCE_DIVIDE: begin
					bank2_source_and_divide <= link_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Toggle marks a completed write for the core-clock side
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			upd_toggle <= 1'b0;
		end else if (link_wr_stb) begin
			upd_toggle <= ~upd_toggle;
		end
	end

	// ==========================================================
	// Readback, unmapped addresses read zero
	always_comb begin
		case (link_addr)
			ADDR_OUTPUT_ENABLE_MASK:  next_rdata = output_enable_mask;
			ADDR_BANK1_SOURCE_DIVIDE: next_rdata = bank1_source_and_divide;
			ADDR_OSC_DRIVE_CONTROL:   next_rdata = oscillator_drive_control;
			ADDR_LOAD_CAP_CODE:       next_rdata = load_capacitor_code;
			ADDR_PUMP_PRODUCT_HIGH:   next_rdata = pump_and_product_high;
			ADDR_PRODUCT_COUNT_LOW:   next_rdata = product_count_low;
			ADDR_ODD_BIT_REF_DIVIDER: next_rdata = odd_bit_and_ref_divider;
			ADDR_CROSSPOINT_SELECT_0: next_rdata = crosspoint_select_0;
			ADDR_CROSSPOINT_SELECT_1: next_rdata = crosspoint_select_1;
			ADDR_CROSSPOINT_SELECT_2: next_rdata = crosspoint_select_2;
			ADDR_BANK2_SOURCE_DIVIDE: next_rdata = bank2_source_and_divide;
			default:                  next_rdata = REG_RESET;
		endcase
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_rdata <= REG_RESET;
		end else begin
			link_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Crossing: registers are stable once the toggle is seen
	logic upd_meta;
	logic upd_sync;
	logic upd_seen;
	logic upd_pulse;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			upd_meta <= 1'b0;
			upd_sync <= 1'b0;
			upd_seen <= 1'b0;
		end else if (clk_en) begin
			upd_meta <= upd_toggle;
			upd_sync <= upd_meta;
			upd_seen <= upd_sync;
		end
	end

	assign upd_pulse = clk_en & (upd_sync ^ upd_seen);

	// ==========================================================
	// Field outputs on the core clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			output_a_enable          <= 1'b0;
			output_b_enable          <= 1'b0;
			output_c_enable          <= 1'b0;
			bank1_source_select      <= 1'b0;
			bank1_divide_value       <= 7'h00;
			bank2_source_select      <= 1'b0;
			bank2_divide_value       <= 7'h00;
			tuning_array_addr_source <= 2'h0;
			load_cap_source          <= 1'b0;
			osc_drive_level          <= 2'h0;
			load_cap_code            <= 8'h00;
			charge_pump_setting      <= 3'h0;
			product_base_count       <= 10'h000;
			product_odd_bit          <= 1'b0;
			ref_divide_field         <= 7'h00;
			ref_divide_total         <= REF_DIV_OFFSET;
			output_a_source_select   <= 3'h7;
			output_b_source_select   <= 3'h7;
			output_c_source_select   <= 3'h7;
		end else if (upd_pulse) begin
			output_a_enable <= output_enable_mask[OE_A_BIT];
			output_b_enable <= output_enable_mask[OE_B_BIT];
			output_c_enable <= output_enable_mask[OE_C_BIT];
			bank1_source_select <= bank1_source_and_divide[SRC_SEL_BIT];
			bank1_divide_value  <= bank1_source_and_divide[6:0];
			bank2_source_select <= bank2_source_and_divide[SRC_SEL_BIT];
			bank2_divide_value  <= bank2_source_and_divide[6:0];
			tuning_array_addr_source <=
				oscillator_drive_control[TUNE_HI_BIT:TUNE_LO_BIT];
			load_cap_source <= oscillator_drive_control[CAP_SRC_BIT];
			osc_drive_level <=
				oscillator_drive_control[DRIVE_HI_BIT:DRIVE_LO_BIT];
			load_cap_code <= load_capacitor_code;
			charge_pump_setting <=
				pump_and_product_high[PUMP_HI_BIT:PUMP_LO_BIT];
			product_base_count <= {pump_and_product_high[1:0],
				product_count_low};
			product_odd_bit <= odd_bit_and_ref_divider[ODD_BIT];
			ref_divide_field <= odd_bit_and_ref_divider[6:0];
			ref_divide_total <= {1'b0, odd_bit_and_ref_divider[6:0]}
				+ REF_DIV_OFFSET;
			output_b_source_select <= {crosspoint_select_0[1:0],
				crosspoint_select_1[7]};
			output_a_source_select <= crosspoint_select_1[3:1];
			output_c_source_select <= {crosspoint_select_1[0],
				crosspoint_select_2[7:6]};
		end
	end

	// ==========================================================
	// Checks
	a_ref_div_total: assert property (@(posedge clk)
		disable iff (!rst_n)
		ref_divide_total == {1'b0, ref_divide_field} + 8'h02)
		else $error("reference divide total is not field plus two");

	a_ref_div_range: assert property (@(posedge clk)
		disable iff (!rst_n)
		ref_divide_total >= 8'h02 && ref_divide_total <= 8'h81)
		else $error("reference divide total out of range");

	a_enable_mask_zero: assert property (@(posedge link_clk)
		disable iff (!rst_n)
		(output_enable_mask & ~OE_WRITE_MASK) == 8'h00)
		else $error("unused enable bits are not zero");

	a_osc_low_zero: assert property (@(posedge link_clk)
		disable iff (!rst_n)
		oscillator_drive_control[2:0] == 3'h0)
		else $error("oscillator control low bits are not zero");

	a_pump_fixed_bits: assert property (@(posedge link_clk)
		disable iff (!rst_n)
		pump_and_product_high[7:5] == 3'h6)
		else $error("charge pump register fixed bits wrong");

	a_xpoint_ones: assert property (@(posedge link_clk)
		disable iff (!rst_n)
		(crosspoint_select_0 & ~XP0_WRITE_MASK) == ~XP0_WRITE_MASK
		&& (crosspoint_select_1 & ~XP1_WRITE_MASK) == ~XP1_WRITE_MASK
		&& (crosspoint_select_2 & ~XP2_WRITE_MASK) == ~XP2_WRITE_MASK)
		else $error("crosspoint reserved bits are not ones");

	a_cap_code_write: assert property (@(posedge link_clk)
		disable iff (!rst_n)
		link_wr_stb && link_addr == ADDR_LOAD_CAP_CODE
		|=> load_capacitor_code == $past(link_wdata))
		else $error("load capacitor code write lost");

	a_odd_bit_write: assert property (@(posedge link_clk)
		disable iff (!rst_n)
		link_wr_stb && link_addr == ADDR_ODD_BIT_REF_DIVIDER
		|=> odd_bit_and_ref_divider[7] == $past(link_wdata[7]))
		else $error("odd product bit write lost");

	a_fields_hold: assert property (@(posedge clk)
		disable iff (!rst_n)
		!upd_pulse |=> $stable(load_cap_code) && $stable(osc_drive_level)
		&& $stable(load_cap_source))
		else $error("field changed without a completed write");

	a_fields_follow: assert property (@(posedge clk)
		disable iff (!rst_n)
		upd_pulse |=> load_cap_code == $past(load_capacitor_code)
		&& load_cap_source == $past(oscillator_drive_control[CAP_SRC_BIT]))
		else $error("field did not follow register after write");

	a_enables_follow: assert property (@(posedge clk)
		disable iff (!rst_n)
		upd_pulse |=> output_a_enable == $past(output_enable_mask[OE_A_BIT])
		&& output_b_enable == $past(output_enable_mask[OE_B_BIT])
		&& output_c_enable == $past(output_enable_mask[OE_C_BIT]))
		else $error("output enables did not follow register");

	a_xpoint_follow: assert property (@(posedge clk)
		disable iff (!rst_n)
		upd_pulse |=>
		output_a_source_select == $past(crosspoint_select_1[3:1]))
		else $error("output A source select did not follow register");

endmodule

// >>> verification/csc_host_model.sv
// Host model: serial engine side that writes and reads the bank.
// Assumes a free-running link clock and a one-cycle write strobe.
`timescale 1ns/1ps

module csc_host_model (
	input  wire logic       link_clk,
	output logic            link_wr_stb,
	output logic      [7:0] link_addr,
	output logic      [7:0] link_wdata,
	input  wire logic [7:0] link_rdata
);
	// ==========================================================
	// Bus cycles
	initial begin
		link_wr_stb = 1'b0;
		link_addr   = 8'h00;
		link_wdata  = 8'h00;
	end

	// Gap of two link cycles lets the core track each write
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge link_clk);
		link_wr_stb = 1'b1;
		link_addr   = a;
		link_wdata  = d;
		@(negedge link_clk);
		link_wr_stb = 1'b0;
		link_wdata  = ~d;
		repeat (2) @(negedge link_clk);
	endtask

	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge link_clk);
		link_addr = a;
		@(negedge link_clk);
		d = link_rdata;
	endtask

	// ==========================================================
	// Reference setup sequences
	task automatic ext_ref(input logic [1:0] band);
		write(8'h12, {3'b000, band, 3'b000});
		write(8'h13, 8'h00);
	endtask

	task automatic xtal(input logic [1:0] drv, input logic [7:0] cap);
		write(8'h12, {3'b001, drv, 3'b000});
		write(8'h13, cap);
	endtask
endmodule

// >>> verification/clock_synth_config_regs_tb_top.sv
// Testbench of the configuration bank with a host model on the link.
// Assumes core clock 50 ns and an unrelated 125 ns link clock.
`timescale 1ns/1ps

module clock_synth_config_regs_tb_top;
	logic       clk = 1'b0;
	logic       link_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       clk_en = 1'b1;
	logic       stb;
	logic [7:0] addr, wdata, rdata, ccode;
	logic       oa, ob, oc, s1, s2, csrc, odd;
	logic [6:0] d1, d2, qf;
	logic [1:0] tune, drv;
	logic [2:0] pump, xa, xb, xc;
	logic [9:0] pb;
	logic [7:0] qt;
	int         err_total = 0;
	int         checked = 0;
	int         cycles = 0;
	logic [7:0] ra [12] = '{8'h09, 8'h0C, 8'h12, 8'h13, 8'h40, 8'h41,
		8'h42, 8'h44, 8'h45, 8'h46, 8'h47, 8'h43};
	logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00,
		8'h00, 8'hFC, 8'h70, 8'h3F, 8'h00, 8'h00};
	logic [7:0] fv [12] = '{8'h34, 8'hFF, 8'hF8, 8'hFF, 8'hDF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};

	initial forever #25 clk = ~clk;
	initial begin
		#17;
		forever #62.5 link_clk = ~link_clk;
	end

	csc_host_model host (.link_clk(link_clk), .link_wr_stb(stb),
		.link_addr(addr), .link_wdata(wdata), .link_rdata(rdata));

	csc_config_regs dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.link_clk(link_clk), .link_wr_stb(stb), .link_addr(addr),
		.link_wdata(wdata), .link_rdata(rdata), .output_a_enable(oa),
		.output_b_enable(ob), .output_c_enable(oc),
		.bank1_source_select(s1), .bank1_divide_value(d1),
		.bank2_source_select(s2), .bank2_divide_value(d2),
		.tuning_array_addr_source(tune), .load_cap_source(csrc),
		.osc_drive_level(drv), .load_cap_code(ccode),
		.charge_pump_setting(pump), .product_base_count(pb),
		.product_odd_bit(odd), .ref_divide_field(qf),
		.ref_divide_total(qt), .output_a_source_select(xa),
		.output_b_source_select(xb), .output_c_source_select(xc));

	// ==========================================================
	// Shared checks
	task automatic chk(input logic [21:0] got, input logic [21:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.read(a, d);
		chk(d, exp);
	endtask

	task automatic settle();
		repeat (12) @(negedge clk);
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		for (int i = 0; i < 12; i++) begin
			rd_chk(ra[i], rv[i]);
		end
		chk({qt, xa, xb, xc, oa, ob, oc}, {8'h02, 9'h1FF, 3'b000});
	endtask

	// All ones: reserved bits forced, unmapped 0x43 ignored
	task automatic t_all_ones();
		for (int i = 0; i < 12; i++) host.write(ra[i], 8'hFF);
		settle();
		for (int i = 0; i < 12; i++) begin
			rd_chk(ra[i], fv[i]);
		end
		chk({oa, ob, oc, s1, d1, s2, d2}, 19'h7FFFF);
		chk({tune, csrc, drv, ccode}, 13'h1FFF);
		chk({pump, pb, odd}, {3'h7, 10'h3FF, 1'b1});
		chk(qt, 8'h81);
		chk({xa, xb, xc}, 9'h1FF);
	endtask

	task automatic t_fields();
		host.write(8'h09, 8'h10);
		host.write(8'h0C, 8'h85);
		host.write(8'h47, 8'h04);
		host.xtal(2'b01, 8'h5A);
		host.write(8'h40, 8'hC9);
		host.write(8'h41, 8'h23);
		host.write(8'h42, 8'h05);
		host.write(8'h44, 8'h02);
		host.write(8'h45, 8'h05);
		host.write(8'h46, 8'h40);
		settle();
		chk({oa, ob, oc}, 3'b100);
		chk({s1, d1, s2, d2}, {1'b1, 7'h05, 1'b0, 7'h04});
		chk({tune, csrc, drv, ccode}, {5'b00101, 8'h5A});
		chk({pump, pb, odd}, {3'h2, 10'h123, 1'b0});
		chk({qf, qt}, {7'h05, 8'h07});
		chk({xa, xb, xc}, {3'd2, 3'd4, 3'd5});
	endtask

	task automatic t_ext_ref();
		host.ext_ref(2'b11);
		settle();
		chk({tune, csrc, drv, ccode}, {5'b00011, 8'h00});
	endtask

	// Core enable low must hold back the new value
	task automatic t_clk_en();
		@(negedge clk);
		clk_en = 1'b0;
		host.write(8'h13, 8'h33);
		settle();
		chk(ccode, 8'h00);
		clk_en = 1'b1;
		settle();
		chk(ccode, 8'h33);
	endtask

	// ==========================================================
	// Main sequence and timeout
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			$display("[ERR] %0t run did not finish in time", $time);
			finish_test();
		end
	end

	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_all_ones();
		t_fields();
		t_ext_ref();
		t_clk_en();
		finish_test();
	end
endmodule
